// ===== verilog/adc_out_pkg.sv
// Shared constants and carrier types for the converter result output port
package adc_out_pkg;

    // ------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------
    localparam int          RESULT_BITS  = 18;
    localparam logic [1:0]  MODE_SERIAL  = 2'h3;
    localparam logic [4:0]  LAST_BIT     = 5'h11;   // Index of final bit, 17
    localparam logic [4:0]  CHAIN_EDGES  = 5'h12;   // Bit periods before chain data, 18
    localparam logic [1:0]  FIFO_DEPTH   = 2'h2;
    localparam logic [17:0] RESULT_RESET = 18'h00000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS  = 1000;        // Conversion length, least time
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_QTR_NS   = 20;          // Quarter of internal bit period
    localparam int SCLK_QTR      = (SCLK_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       resetPin;       // Active high device reset
        logic       convertStartN;
        logic       chipSelectN;
        logic       readN;
        logic       serialClkIn;
        logic       readModeOrChainIn;
        logic [1:0] interfaceMode;
        logic       clockSourceSelect;
        logic       bitClockInvert;
        logic       frameSyncInvert;
        logic       resultCodingSelect;
    } pin_in_t;

    typedef struct packed {
        logic readOverrunFlag;
        logic frameSync;
        logic bitClock;
        logic serialResultOut;
    } serial_pins_t;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_LATCH} conv_state_t;

endpackage

// ===== verilog/adc_result_port.sv
// Result output port of an 18-bit sampling converter: parallel and serial
`timescale 1ns/10ps
// Operation
// - Mode 3 turns bits 10-13 serial
// - Bits 14-17 driven outputs in both modes
// - Shift result MSB first, chosen coding
// - Internal clock: data stable both edges
// - External clock, no invert: rising updates
// - External clock, inverted: falling updates
// - Bit clock pin direction follows source
// - Frame sync high during valid master data
// - Inverted frame sync low during master data
// - Unfinished slave read: discard, pulse error
// - Busy high until result latched
// - Drivers on only with select, read low
// - Chip select gates external bit clock
// - Reset pin aborts conversion
// - Clock select picks internal or external
// - Chain input follows after 18 bits
// - Read mode: during or after conversion
// - Convert start falling edge begins conversion
module adc_result_port (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  clkEn,
    // Host pins, asynchronous
    input  wire adc_out_pkg::pin_in_t  hostPins,
    // Converter core code, offset binary, same clock
    input  wire logic [17:0]           sampleCode,
    // Result bus pins
    output logic      [17:0]           dataOut,
    output logic      [17:0]           dataOe,
    output logic                       busy
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    adc_out_pkg::pin_in_t pinA;
    adc_out_pkg::pin_in_t pinB;
    adc_out_pkg::pin_in_t pinPrev;

    // Two flops per pin, a third copy for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pinA    <= '{default: 1'b1, interfaceMode: 2'h0, resetPin: 1'b0};
            pinB    <= '{default: 1'b1, interfaceMode: 2'h0, resetPin: 1'b0};
            pinPrev <= '{default: 1'b1, interfaceMode: 2'h0, resetPin: 1'b0};
        end else if (clkEn) begin
            pinA    <= hostPins;
            pinB    <= pinA;
            pinPrev <= pinB;
        end
    end

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    wire clr        = pinB.resetPin;
    wire serialMode = (pinB.interfaceMode == adc_out_pkg::MODE_SERIAL);
    wire extClk     = pinB.clockSourceSelect;
    wire outEn      = !pinB.chipSelectN && !pinB.readN;
    wire convFall   = pinPrev.convertStartN && !pinB.convertStartN;
    wire sclkRise   = !pinPrev.serialClkIn && pinB.serialClkIn;
    wire sclkFall   = pinPrev.serialClkIn && !pinB.serialClkIn;
    // Bit clock edges count only while selected
    wire activeEdge = !pinB.chipSelectN &&
                      (pinB.bitClockInvert ? sclkFall : sclkRise);

    // Offset binary passes through; two's complement flips the sign bit
    function automatic logic [17:0] codeWord(input logic [17:0] w, input logic ob);
        codeWord = ob ? w : {~w[17], w[16:0]};
    endfunction

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    adc_out_pkg::conv_state_t state;
    logic [7:0]               convCount;
    logic [17:0]              convWord;

    wire pushValid = (state == adc_out_pkg::ST_LATCH);
    wire pushReady;
    wire convDone  = pushValid && pushReady;

    // Busy spans conversion and the wait for buffer room
    assign busy = (state != adc_out_pkg::ST_IDLE);

    // Start on convert edge, count down, then hand the word on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= adc_out_pkg::ST_IDLE;
            convCount <= 8'h00;
            convWord  <= adc_out_pkg::RESULT_RESET;
        end else if (clkEn) begin
            if (clr) begin
                state     <= adc_out_pkg::ST_IDLE;
                convCount <= 8'h00;
            end else begin
                case (state)
                    adc_out_pkg::ST_IDLE: begin
                        if (convFall) begin
                            state     <= adc_out_pkg::ST_CONVERT;
                            convCount <= 8'(adc_out_pkg::CONV_CYCLES - 1);
                        end
                    end
                    adc_out_pkg::ST_CONVERT: begin
                        if (convCount == 8'h00) begin
                            state    <= adc_out_pkg::ST_LATCH;
                            convWord <= sampleCode;
                        end else begin
                            convCount <= convCount - 8'h01;
                        end
                    end
                    adc_out_pkg::ST_LATCH: begin
                        if (pushReady) begin
                            state <= adc_out_pkg::ST_IDLE;
                        end
                    end
                    default: state <= adc_out_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Two-entry result buffer
    // ------------------------------------------------------------
    logic [17:0] fifoMem [2];
    logic        wrPtr;
    logic        rdPtr;
    logic [1:0]  fifoCount;
    wire         popReady;

    // A full buffer stalls the sequencer, which keeps busy high
    assign pushReady = (fifoCount != adc_out_pkg::FIFO_DEPTH);
    wire popValid    = (fifoCount != 2'h0);
    wire doPush      = pushValid && pushReady;
    wire doPop       = popValid && popReady;
    wire [17:0] fifoHead = fifoMem[rdPtr];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr     <= 1'b0;
            rdPtr     <= 1'b0;
            fifoCount <= 2'h0;
        end else if (clkEn) begin
            if (clr) begin
                wrPtr     <= 1'b0;
                rdPtr     <= 1'b0;
                fifoCount <= 2'h0;
            end else begin
                wrPtr     <= wrPtr ^ doPush;
                rdPtr     <= rdPtr ^ doPop;
                fifoCount <= fifoCount + {1'b0, doPush} - {1'b0, doPop};
            end
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge clk) begin
        if (clkEn && doPush) begin
            fifoMem[wrPtr] <= convWord;
        end
    end

    // ------------------------------------------------------------
    // Serial shifter
    // ------------------------------------------------------------
    logic [17:0] shiftReg;
    logic [17:0] lastWord;
    logic        shifting;
    logic [4:0]  bitCount;
    logic [4:0]  edgeCount;
    logic [1:0]  phase;
    logic [1:0]  qtrCount;
    logic        overrunFlag;

    // Master read waits for conversion end unless read mode says during
    wire intGo  = pinB.readModeOrChainIn ? busy : !busy;
    wire startOk = !shifting && outEn && (extClk || intGo);
    assign popReady = serialMode ? startOk : 1'b1;
    wire loadInt = doPop && serialMode && !extClk;

    wire qtrEnd  = (qtrCount == 2'(adc_out_pkg::SCLK_QTR - 1));
    wire bitEnd  = qtrEnd && (phase == 2'h3);
    wire intRun  = shifting && !extClk;
    // Slave read incomplete when a new result arrives
    wire overrun = serialMode && extClk && shifting &&
                   (edgeCount < adc_out_pkg::CHAIN_EDGES) && convDone;
    // First external edge only opens the frame; later ones advance
    wire extShift = shifting && extClk && activeEdge && (edgeCount != 5'h00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shiftReg <= adc_out_pkg::RESULT_RESET;
            lastWord <= adc_out_pkg::RESULT_RESET;
            shifting <= 1'b0;
        end else if (clkEn) begin
            if (clr) begin
                shiftReg <= adc_out_pkg::RESULT_RESET;
                shifting <= 1'b0;
            end else if (doPop) begin
                shiftReg <= codeWord(fifoHead, pinB.resultCodingSelect);
                lastWord <= codeWord(fifoHead, pinB.resultCodingSelect);
                shifting <= serialMode;
            end else begin
                if (extShift) begin
                    shiftReg <= {shiftReg[16:0], pinB.readModeOrChainIn};
                end else if (intRun && bitEnd) begin
                    shiftReg <= {shiftReg[16:0], 1'b0};
                end
                if (overrun) begin
                    shifting <= 1'b0;
                end else if (extClk && !outEn) begin
                    shifting <= 1'b0;
                end else if (intRun && bitEnd && bitCount == adc_out_pkg::LAST_BIT) begin
                    shifting <= 1'b0;
                end
            end
        end
    end

    // Bit, edge and phase counters for both clock sources
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCount  <= 5'h00;
            edgeCount <= 5'h00;
            phase     <= 2'h0;
            qtrCount  <= 2'h0;
        end else if (clkEn) begin
            if (clr || doPop) begin
                bitCount  <= 5'h00;
                edgeCount <= 5'h00;
                phase     <= 2'h0;
                qtrCount  <= 2'h0;
            end else if (intRun) begin
                qtrCount <= qtrEnd ? 2'h0 : qtrCount + 2'h1;
                phase    <= qtrEnd ? phase + 2'h1 : phase;
                bitCount <= bitEnd ? bitCount + 5'h01 : bitCount;
            end else if (shifting && activeEdge &&
                         edgeCount != adc_out_pkg::CHAIN_EDGES) begin
                edgeCount <= edgeCount + 5'h01;
            end
        end
    end

    // Error flag is a single-cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overrunFlag <= 1'b0;
        end else if (clkEn) begin
            overrunFlag <= overrun && !clr;
        end
    end

    // ------------------------------------------------------------
    // Pin muxing and drivers
    // ------------------------------------------------------------
    adc_out_pkg::serial_pins_t ser;
    // One assignment drives the whole group, so the struct has a single driver;
    // bit clock is high in the middle two quarters so data is stable at both edges
    assign ser = '{
        readOverrunFlag: overrunFlag,
        frameSync:       intRun ^ pinB.frameSyncInvert,
        bitClock:        (intRun && (phase == 2'h1 || phase == 2'h2))
                         ^ pinB.bitClockInvert,
        serialResultOut: shiftReg[17]
    };

    // Shared pins carry the serial group only in mode 3
    wire [17:0] next_dataOut = serialMode ?
        {lastWord[17:14], ser, 10'h000} : lastWord;
    // Bit clock pin is an input when the host supplies it
    wire [17:0] next_dataOe  = !outEn ? 18'h00000 :
        serialMode ? {4'hf, 2'h3, !extClk, 1'b1, 10'h000} :
        18'h3ffff;

    // Registered so pins never glitch from the mux
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dataOut <= 18'h00000;
            dataOe  <= 18'h00000;
        end else if (clkEn) begin
            dataOut <= next_dataOut;
            dataOe  <= next_dataOe;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_int_load;
        loadInt;
    endsequence

    sequence s_int_frame;
        shifting [*8] ##137 !shifting;
    endsequence

    a_busy_fall_latch: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr) $fell(busy) |-> $past(doPush))
        else $error("busy fell without a latched result");

    a_conv_start: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr)
        convFall && !busy |=> busy [*8])
        else $error("convert edge did not start a conversion");

    a_reset_abort: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn) clr |=> !busy && !shifting)
        else $error("reset pin did not abort");

    a_drivers_off: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn) !outEn |=> dataOe == 18'h00000)
        else $error("drivers on without select and read");

    a_upper_bits_driven: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn) outEn |=> &dataOe[17:14])
        else $error("upper result bits not driven");

    a_int_frame_len: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr) s_int_load |=> s_int_frame)
        else $error("internal read not eighteen bits long");

    a_sync_level: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn)
        serialMode && !extClk |=>
        dataOut[12] == ($past(shifting) ^ $past(pinB.frameSyncInvert)))
        else $error("frame sync level wrong");

    a_int_data_stable: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr)
        intRun && !doPop && $past(intRun) && shiftReg != $past(shiftReg)
        |-> phase == 2'h0 && qtrCount == 2'h0)
        else $error("internal data changed inside a bit");

    a_ext_gate: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr)
        pinB.chipSelectN && extClk |=> shiftReg == $past(shiftReg))
        else $error("external clock moved data while deselected");

    a_ext_shift: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr)
        extShift && !doPop |=> shiftReg == {$past(shiftReg[16:0]), $past(pinB.readModeOrChainIn)})
        else $error("external edge did not advance data");

    a_overrun_pulse: assert property (@(posedge clk)
        disable iff (!rst_n || !clkEn || clr) overrun |=> overrunFlag ##1 !overrunFlag)
        else $error("read error pulse wrong");

endmodule

// ===== verif/host_serial_model.sv
// Host side model: makes the external bit clock and captures serial result bits
`timescale 1ns/10ps
module host_serial_model (
    // Result pins seen by the host
    input  wire logic [17:0] dataOut,
    input  wire logic [17:0] dataOe,
    // Host side settings
    input  wire logic        fsInv,
    input  wire logic        clkInv,
    // External bit clock for slave reads
    output logic             extClk,
    // Captured bits, newest in bit 0
    output logic [19:0]      capWord,
    output int               capCount
);
    logic fsAct;

    // ----------------------------------------------------------------
    // Master reads
    // ----------------------------------------------------------------
    // Frame counts only while sync is driven at its active level
    assign fsAct = dataOe[12] && (dataOut[12] ^ fsInv);

    initial begin
        extClk   = 1'b0;
        capWord  = '0;
        capCount = 0;
    end

    // Only master frames restart the capture; slave reads restart it themselves
    always @(posedge fsAct) begin
        if (dataOe[11]) begin
            capCount = 0;
            capWord  = '0;
        end
    end

    // Rising bit clock sits a quarter or three quarters into the bit, so data must already be settled here
    always @(posedge dataOut[11]) begin
        if (fsAct && dataOe[11]) begin
            capWord  = {capWord[18:0], dataOe[10] ? dataOut[10] : ~dataOut[10]};
            capCount = capCount + 1;
        end
    end

    // ----------------------------------------------------------------
    // Slave reads
    // ----------------------------------------------------------------
    // Clock rests at its idle level between frames; n = 0 parks it and clears the capture, with no edges
    task automatic run_slave(input int n);
        extClk   = clkInv;
        capCount = 0;
        capWord  = '0;
        repeat (n) begin
            #62.5;
            extClk = ~clkInv;
            #62.5;
            // A released data pin has no pull, so it reads as the inverse here
            capWord  = {capWord[18:0], dataOe[10] ? dataOut[10] : ~dataOut[10]};
            capCount = capCount + 1;
            extClk   = clkInv;
        end
    endtask
endmodule

// ===== verif/tb_adc_result_port.sv
// Self-checking bench for the converter result output port
`timescale 1ns/10ps
module tb_adc_result_port;
    logic                 clk;
    logic                 rst_n;
    logic                 clkEn;
    adc_out_pkg::pin_in_t pins;
    adc_out_pkg::pin_in_t hostPins;
    logic [17:0]          sampleCode;
    logic [17:0]          dataOut;
    logic [17:0]          dataOe;
    logic                 busy;
    logic                 extClk;
    logic [19:0]          capWord;
    int                   capCount;
    int                   err_total;
    int                   n_tests;
    logic                 seen;
    int                   k;

    // Bit clock pin comes from the host model, all else from the bench
    always_comb begin
        hostPins             = pins;
        hostPins.serialClkIn = extClk;
    end

    adc_result_port DUT (
        .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .hostPins(hostPins),
        .sampleCode(sampleCode), .dataOut(dataOut), .dataOe(dataOe), .busy(busy)
    );

    host_serial_model host (
        .dataOut(dataOut), .dataOe(dataOe), .fsInv(pins.frameSyncInvert),
        .clkInv(pins.bitClockInvert), .extClk(extClk), .capWord(capWord),
        .capCount(capCount)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Compare and access tasks
    // ----------------------------------------------------------------
    task automatic check_word(input logic [19:0] got, input logic [19:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string msg);
        check_word({19'h00000, got}, {19'h00000, exp}, msg);
    endtask

    function automatic logic [17:0] coded(input logic [17:0] c);
        return pins.resultCodingSelect ? c : {~c[17], c[16:0]};
    endfunction

    task automatic wait_busy(input logic lvl, input int limit);
        for (k = 0; k < limit && busy !== lvl; k++) @(posedge clk);
        check_bit(busy, lvl, "busy level");
    endtask

    // Start pin is held low until busy answers, so the edge cannot be missed
    task automatic convert(input logic [17:0] code);
        sampleCode         <= code;
        pins.convertStartN <= 1'b0;
        wait_busy(1'b1, 10);
        pins.convertStartN <= 1'b1;
    endtask

    task automatic conv_wait(input logic [17:0] code);
        int n;
        convert(code);
        for (n = 0; n < 200 && busy === 1'b1; n++) @(posedge clk);
        check_bit(n >= 100 && n <= 104, 1'b1, "busy length");
    endtask

    task automatic select(input logic lvl);
        pins.chipSelectN <= lvl;
        pins.readN       <= lvl;
    endtask

    // With keep set the select stays low, so a waiting word follows at once
    task automatic read_master(input logic [17:0] exp, input logic keep = 1'b0);
        select(1'b0);
        for (k = 0; k < 60 && host.fsAct !== 1'b1; k++) @(posedge clk);
        check_bit(dataOe[11], 1'b1, "bit clock not driven");
        check_word(20'(dataOe[17:14]), 20'hf, "upper pins not driven");
        for (k = 0; k < 200 && host.fsAct !== 1'b0; k++) @(posedge clk);
        check_word(20'(capCount), 20'h12, "bits in frame");
        check_word(20'(capWord[17:0]), 20'(exp), "serial word");
        if (!keep) begin
            select(1'b1);
            @(posedge clk);
        end
    endtask

    // Clock edges while deselected come first; they must move nothing
    task automatic read_slave(input logic [17:0] exp);
        host.run_slave(2);
        select(1'b0);
        repeat (4) @(posedge clk);
        check_bit(dataOe[11], 1'b0, "bit clock pin driven in slave");
        host.run_slave(20);
        check_word(capWord, {exp, 2'h3}, "slave word and chain");
        @(posedge clk);
        select(1'b1);
        @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("Checks made %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        err_total  = 0;
        n_tests    = 0;
        rst_n      = 1'b0;
        clkEn      = 1'b1;
        sampleCode = 18'h00000;
        pins       = '0;
        pins.convertStartN = 1'b1;
        pins.chipSelectN   = 1'b1;
        pins.readN         = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_word(20'(dataOe), 20'h0, "drivers on after reset");
        check_bit(busy, 1'b0, "busy after reset");
        $display("Test done: reset");
        // Parallel reads in both codings; a raised read strobe alone releases the bus
        for (int c = 1; c >= 0; c--) begin
            pins.resultCodingSelect <= c[0];
            conv_wait(18'h2a5c3 ^ {18{c[0]}});
            select(1'b0);
            repeat (5) @(posedge clk);
            check_word(20'(dataOe), 20'h3ffff, "parallel drivers");
            check_word(20'(dataOut), 20'(coded(18'h2a5c3 ^ {18{c[0]}})),
                       "parallel data");
            pins.readN <= 1'b1;
            repeat (5) @(posedge clk);
            check_word(20'(dataOe), 20'h0, "drivers with read high");
            select(1'b1);
        end
        $display("Test done: parallel");
        // Serial master, frame sync and bit clock both polarities, read after conversion
        pins.interfaceMode <= adc_out_pkg::MODE_SERIAL;
        for (int f = 0; f < 2; f++) begin
            pins.frameSyncInvert <= f[0];
            pins.bitClockInvert  <= f[0];
            conv_wait(18'h31c05 + 18'(f));
            read_master(coded(18'h31c05 + 18'(f)));
        end
        $display("Test done: serial master");
        // Buffer full stalls busy; first word read during conversion, last two
        // back to back, since a held select starts the next frame at once
        pins.readModeOrChainIn <= 1'b1;
        conv_wait(18'h10001);
        conv_wait(18'h20002);
        convert(18'h30003);
        repeat (120) @(posedge clk);
        check_bit(busy, 1'b1, "busy while buffer full");
        read_master(coded(18'h10001));
        wait_busy(1'b0, 20);
        pins.readModeOrChainIn <= 1'b0;
        read_master(coded(18'h20002), 1'b1);
        read_master(coded(18'h30003));
        $display("Test done: buffer");
        // Serial slave with both clock polarities, chain input high
        pins.clockSourceSelect <= 1'b1;
        pins.readModeOrChainIn <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            pins.bitClockInvert <= i[0];
            conv_wait(18'h0f0f1 << i);
            read_slave(coded(18'h0f0f1 << i));
        end
        $display("Test done: serial slave");
        // Unfinished slave read overrun by the next conversion
        pins.bitClockInvert <= 1'b0;
        conv_wait(18'h12345);
        host.run_slave(0);
        select(1'b0);
        repeat (4) @(posedge clk);
        host.run_slave(5);
        convert(18'h23456);
        seen = 1'b0;
        for (int i = 0; i < 150; i++) begin
            @(posedge clk);
            seen = seen | (dataOut[13] & dataOe[13]);
        end
        check_bit(seen, 1'b1, "overrun flag pulse");
        select(1'b1);
        $display("Test done: overrun");
        // Device reset pin aborts a running conversion
        @(posedge clk);
        convert(18'h0aaaa);
        repeat (20) @(posedge clk);
        pins.resetPin <= 1'b1;
        wait_busy(1'b0, 8);
        pins.resetPin <= 1'b0;
        $display("Test done: reset pin");
        report_and_stop();
    end

    // Watchdog sized well past the few thousand cycles the tests need
    initial begin
        #500000;
        err_total++;
        report_and_stop();
    end
endmodule
